//--- verilog/twi_slave_ctl.sv
// Two-wire bus slave with control, command and status registers on AHB-Lite
`timescale 1ns/1ns
// Function
// (R01) Zero priority level blocks every interrupt request.
// (R02) Byte and address/stop interrupts need their flag and enable set.
// (R03) Slave works only while the enable bit is set.
// (R04) STOP sets the address/stop flag only when stop-flag enable is set.
// (R05) Match-all accepts every address, else only the own address; the code also accepts address 0 when own address bit 0 is set.
// (R06) Smart mode performs acknowledge on data register read.
// (R07) Software writes zeros to unused upper bits of second control.
// (R08) Ack choice 0 sends ACK, 1 NACK, on command or smart read.
// (R09) Command bits are strobes and read as zero.
// (R10) Acknowledge driven only for received bytes.
// (R11) 00 nothing, 01 reserved, 10 completes transaction.
// (R12) Command 11 after address: ack, then receive or set byte-done.
// (R13) Command 11 after data: ack and await byte in write direction.
// (R14) Command write clears flags and stretch, releases SCL.
// (R15) Ack choice written with command applies first.
// (R16) Byte-done set on clean byte, write-one clears, SCL held.
// (R17) Address/stop flag on match or collision; stretch only for address.
// (R18) Stretch status follows flags, read only.
// (R19) Status holds last master acknowledge bit.
// (R20) Collision sets flag, stops driving; cleared by write-one or START.
// (R21) Bus error on START/STOP off nine-bit boundary, when checking on.
// (R22) Direction captures address read/write bit; source bit recorded.
// (R23) Source bit 0 for STOP, 1 for address.
module twi_slave_ctl (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 ce,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      scl_o,
	output logic                      scl_oe,
	output logic                      sda_o,
	output logic                      sda_oe,
	output logic                      irq,
	output twi_slave_pkg::irq_lvl_t   irq_level
);
	import twi_slave_pkg::*;

	slv_regs_s  q;
	slv_regs_s  d;
	line_evt_s  evt;
	logic       acc;
	logic       wr;
	logic [7:0] wd;
	logic       en;
	logic       rd_data;
	logic       cmd_wr;
	logic [1:0] cmd;
	logic       ack_eff;
	logic       do_resp;
	logic       match;

	twi_line_sync u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.evt     (evt)
	);

	// Register read view; command bits always read zero
	function automatic logic [7:0] rd_mux(input logic [2:0] idx,
		input slv_regs_s r);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			IDX_CTRL_A: v = r.ctrl_a;
			IDX_CTRL_B: v = {5'h00, r.ack_choice, 2'h0}; // see (R09)
			IDX_STATUS: v = {r.byte_done_flag, r.addr_stop_flag, r.hold, r.last_master_ack,
				r.clash, r.illegal_bus_condition, r.dir, r.ap};
			IDX_OWN:    v = r.own_addr;
			IDX_DATA:   v = r.data;
			IDX_AUX:    v = {7'h00, r.bus_chk_en};
			default:    v = 8'h00;
		endcase
		return v;
	endfunction

	// Bus decode and address match terms
	assign acc     = hsel & htrans[1] & hready;
	assign wr      = q.ph_valid & q.ph_write;
	assign wd      = hwdata[7:0];
	assign en      = q.ctrl_a[CA_EN];
	assign rd_data = acc & ~hwrite & (haddr[4:2] == IDX_DATA);
	assign cmd_wr  = wr & (q.ph_idx == IDX_CTRL_B);
	assign cmd     = cmd_wr ? wd[1:0] : CMD_NO_ACTION_CODE;
	assign ack_eff = cmd_wr ? wd[CB_ACK] : q.ack_choice; // see (R15)
	assign match   = q.ctrl_a[CA_MATCH_ALL_ENABLE]
		| (q.shift[7:1] == q.own_addr[7:1])
		| (q.own_addr[0] & (q.shift[7:1] == 7'h00)); // see (R05)
	// Smart read of a received byte acts like a response command
	assign do_resp = (q.st == S_HOLD) & ((cmd == CMD_RESPONSE) // see (R06)
		| (rd_data & q.ctrl_a[CA_AUTO_ACK_ON_READ] & (q.addr_stop_flag | (q.byte_done_flag & ~q.dir))));

	// Next-state logic: bus access, software effects, then bus events
	always_comb begin
		d = q;
		// Address phase capture and read data
		d.ph_valid = acc;
		d.ph_write = hwrite;
		d.ph_idx   = haddr[4:2];
		if (acc & ~hwrite) begin
			d.rdata = {24'h000000, rd_mux(haddr[4:2], q)};
		end
		// Data phase writes
		if (wr) begin
			case (q.ph_idx)
				IDX_CTRL_A: d.ctrl_a = wd;
				IDX_CTRL_B: d.ack_choice = wd[CB_ACK];
				IDX_STATUS: begin
					if (wd[ST_DIF]) d.byte_done_flag = 1'b0;
					if (wd[ST_ADDR_STOP_FLAG]) d.addr_stop_flag = 1'b0;
					if (wd[ST_DRIVE_CLASH_FLAG]) d.clash = 1'b0; // see (R20)
					if (wd[ST_BERR]) d.illegal_bus_condition = 1'b0; // see (R21)
					if (!d.byte_done_flag && !d.addr_stop_flag) d.hold = 1'b0; // see (R18)
				end
				IDX_OWN:    d.own_addr = wd;
				IDX_DATA:   d.data = wd;
				IDX_AUX:    d.bus_chk_en = wd[AUX_CHK];
				default: ;
			endcase
		end
		// Data register access clears flags and releases SCL
		if (rd_data | (wr & (q.ph_idx == IDX_DATA))) begin
			d.byte_done_flag  = 1'b0;
			d.addr_stop_flag = 1'b0;
			d.hold = 1'b0;
			if (wr & (q.st == S_HOLD) & q.dir & ~q.addr_stop_flag) begin
				d.st    = S_TX;
				d.shift = wd;
				d.sda_drive = ~wd[7];
				d.bitcnt = 4'h0;
			end
		end
		// Valid commands release the line
		if (cmd[1] | do_resp) begin
			d.byte_done_flag  = 1'b0; // see (R14)
			d.addr_stop_flag = 1'b0; // see (R17)
			d.hold = 1'b0; // see (R14)
		end
		if ((q.st == S_HOLD) & (cmd == CMD_COMPLETE)) begin
			d.st = S_IDLE; // see (R11)
			if (!q.dir) begin
				d.st = S_ACK;
				d.aft = AFT_IDLE;
			end
		end else if (do_resp) begin
			if (q.addr_stop_flag) begin
				d.st  = S_ACK; // see (R12)
				d.aft = q.dir ? AFT_TXHOLD : AFT_RX;
			end else if (!q.dir) begin
				d.st  = S_ACK; // see (R13)
				d.aft = AFT_RX;
			end else begin
				d.st    = S_TX; // see (R13)
				d.shift = q.data;
				d.sda_drive = ~q.data[7] & ~q.clash;
				d.bitcnt = 4'h0;
			end
		end
		if ((d.st == S_ACK) & (q.st == S_HOLD)) begin
			d.sda_drive = (ack_eff == ACK_SEND) & ~q.clash; // see (R08)
			d.ack_rose  = 1'b0;
		end
		// Nine-bit framing for bus error checks
		if (evt.rise & q.frame_open) begin
			d.frame_cnt = (q.frame_cnt == FRAME_LAST) ? 4'h0
				: q.frame_cnt + 4'h1;
		end
		if ((evt.start | evt.stop) & q.frame_open & q.bus_chk_en
			& (q.frame_cnt != 4'h0)) begin
			d.illegal_bus_condition = 1'b1; // see (R21)
		end
		if (evt.start) begin
			d.frame_open = 1'b1;
			d.frame_cnt  = 4'h0;
		end else if (evt.stop) begin
			d.frame_open = 1'b0;
		end
		// Bus engine
		if (!en) begin
			d.st = S_IDLE; // see (R03)
			d.sda_drive = 1'b0;
			d.hold = 1'b0;
			d.addressed = 1'b0;
		end else if (evt.start) begin
			d.clash  = 1'b0; // see (R20)
			d.st     = S_ADDR;
			d.bitcnt = 4'h0;
			d.sda_drive = 1'b0;
			d.addressed = 1'b0;
		end else if (evt.stop) begin
			d.sda_drive = 1'b0;
			d.st = S_IDLE;
			d.addressed = 1'b0;
			// Addressed since START, even if a command already went idle
			if (q.ctrl_a[CA_STOP_FLAG_ENABLE] & q.addressed) begin
				d.addr_stop_flag = 1'b1; // see (R04)
				d.ap   = 1'b0; // see (R23)
			end
		end else begin
			case (q.st)
				S_ADDR, S_RX: begin
					if (evt.rise) begin
						d.shift  = {q.shift[6:0], evt.sda};
						d.bitcnt = q.bitcnt + 4'h1;
					end
					if (evt.fall & (q.bitcnt == BYTE_BITS)) begin
						d.bitcnt = 4'h0;
						if (q.st == S_RX) begin
							d.data = q.shift;
							d.byte_done_flag  = 1'b1; // see (R16)
							d.hold = 1'b1; // see (R18)
							d.st   = S_HOLD;
						end else if (match) begin
							d.data = q.shift;
							d.addr_stop_flag = 1'b1; // see (R17)
							d.ap   = 1'b1; // see (R23)
							d.dir  = q.shift[0]; // see (R22)
							d.addressed = 1'b1;
							d.hold = 1'b1; // see (R17)
							d.st   = S_HOLD;
						end else begin
							d.st = S_IDLE;
						end
					end
				end
				S_ACK: begin
					if (evt.rise) begin
						d.ack_rose = 1'b1;
						if (!q.sda_drive & !evt.sda & !q.clash) begin
							d.clash = 1'b1; // see (R20)
							d.addr_stop_flag  = 1'b1; // see (R17)
						end
					end
					if (evt.fall & q.ack_rose) begin
						d.sda_drive = 1'b0; // see (R10)
						d.ack_rose  = 1'b0;
						d.bitcnt    = 4'h0;
						case (q.aft)
							AFT_RX:     d.st = S_RX;
							AFT_TXHOLD: begin
								d.byte_done_flag  = 1'b1; // see (R12)
								d.hold = 1'b1;
								d.st   = S_HOLD;
							end
							default:    d.st = S_IDLE;
						endcase
					end
				end
				S_TX: begin
					if (evt.rise & q.shift[7] & ~evt.sda & ~q.clash) begin
						d.clash = 1'b1; // see (R20)
						d.addr_stop_flag  = 1'b1; // see (R17)
						d.sda_drive = 1'b0;
					end
					if (evt.fall) begin
						d.shift  = {q.shift[6:0], 1'b0};
						d.bitcnt = q.bitcnt + 4'h1;
						d.sda_drive = ~q.shift[6] & ~d.clash; // see (R20)
						if (q.bitcnt == BYTE_BITS - 4'h1) begin
							d.sda_drive = 1'b0;
							d.st = S_TX_ACK;
						end
					end
				end
				S_TX_ACK: begin
					if (evt.rise) begin
						d.last_master_ack    = evt.sda; // see (R19)
						d.ack_rose = 1'b1;
					end
					if (evt.fall & q.ack_rose) begin
						d.ack_rose = 1'b0;
						d.byte_done_flag  = 1'b1; // see (R16)
						d.hold = 1'b1;
						d.st   = S_HOLD;
					end
				end
				default: ;
			endcase
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q        <= '0;
			q.st     <= S_IDLE;
			q.aft    <= AFT_IDLE;
			q.ctrl_a <= CTRL_A_RST;
			q.own_addr <= OWN_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// Bus answer, open-drain pins and interrupt request
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = q.rdata;
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe    = q.hold; // see (R16)
	assign sda_oe    = q.sda_drive & ~q.clash; // see (R20)
	assign irq_level = q.ctrl_a[CA_LVL_HI:CA_LVL_LO];
	assign irq = (irq_level != 2'h0)
		& ((q.byte_done_flag & q.ctrl_a[CA_BYTE_IRQ_ENABLE])
		| (q.addr_stop_flag & q.ctrl_a[CA_ADDR_STOP_IRQ_ENABLE])); // see (R01) (R02)

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	irq_level_gate_a: assert property ( // see (R01)
		(irq_level == 2'h0) |-> !irq)
		else $error("interrupt raised at level zero");
	irq_cause_a: assert property ( // see (R02)
		(irq_level != 2'h0) && q.addr_stop_flag && q.ctrl_a[CA_ADDR_STOP_IRQ_ENABLE] |-> irq)
		else $error("address interrupt not raised");
	disabled_quiet_a: assert property ( // see (R03)
		ce && !en |=> !scl_oe && !sda_oe)
		else $error("disabled slave drives the bus");
	stop_no_flag_a: assert property ( // see (R04)
		ce && en && evt.stop && !q.ctrl_a[CA_STOP_FLAG_ENABLE] && !q.addr_stop_flag
		&& !(wr && q.ph_idx == IDX_CTRL_A) |=> !q.addr_stop_flag)
		else $error("stop set flag while disabled");
	cmd_read_zero_a: assert property ( // see (R09)
		ce && acc && !hwrite && haddr[4:2] == IDX_CTRL_B
		|=> hrdata[1:0] == 2'h0)
		else $error("command bits read nonzero");
	cmd_release_a: assert property ( // see (R14)
		ce && cmd_wr && wd[1] && q.st == S_HOLD |=> !scl_oe && !q.byte_done_flag)
		else $error("command did not release clock");
	flag_holds_a: assert property ( // see (R16)
		q.byte_done_flag |-> q.hold && scl_oe)
		else $error("byte flag without clock stretch");
	ack_drive_a: assert property ( // see (R08)
		ce && cmd_wr && wd[1:0] == CMD_RESPONSE && !wd[CB_ACK]
		&& q.st == S_HOLD && !q.dir && !q.clash && en
		&& !evt.start && !evt.stop |=> sda_oe)
		else $error("ACK not driven after response");
	clash_release_a: assert property ( // see (R20)
		$rose(q.clash) |-> !sda_oe && q.addr_stop_flag)
		else $error("collision without flag or release");
	addr_source_a: assert property ( // see (R23)
		$rose(q.hold) && q.addr_stop_flag |-> q.ap)
		else $error("address stretch with stop source");

	addr_match_c: cover property ($rose(q.addr_stop_flag) && q.ap);
	tx_byte_c: cover property (q.st == S_TX_ACK ##[1:200] q.byte_done_flag);
	collision_c: cover property ($rose(q.clash));
	bus_error_c: cover property ($rose(q.illegal_bus_condition));

endmodule

//--- verilog/twi_slave_pkg.sv
// Constants, types and state layout for the two-wire slave control block
package twi_slave_pkg;

	// Register indices; byte address is four times the index
	localparam logic [2:0] IDX_CTRL_A = 3'h0;
	localparam logic [2:0] IDX_CTRL_B = 3'h1;
	localparam logic [2:0] IDX_STATUS = 3'h2;
	localparam logic [2:0] IDX_OWN    = 3'h3;
	localparam logic [2:0] IDX_DATA   = 3'h4;
	localparam logic [2:0] IDX_AUX    = 3'h6;

	// First control register fields
	localparam int CA_LVL_HI = 7;
	localparam int CA_LVL_LO = 6;
	localparam int CA_BYTE_IRQ_ENABLE   = 5;
	localparam int CA_ADDR_STOP_IRQ_ENABLE  = 4;
	localparam int CA_EN     = 3;
	localparam int CA_STOP_FLAG_ENABLE   = 2;
	localparam int CA_MATCH_ALL_ENABLE   = 1;
	localparam int CA_AUTO_ACK_ON_READ   = 0;

	// Second control register fields and command codes
	localparam int         CB_ACK        = 2;
	localparam logic [1:0] CMD_NO_ACTION_CODE     = 2'h0;
	localparam logic [1:0] CMD_RESERVED  = 2'h1;
	localparam logic [1:0] CMD_COMPLETE  = 2'h2;
	localparam logic [1:0] CMD_RESPONSE  = 2'h3;
	localparam logic       ACK_SEND      = 1'b0;

	// Status register fields
	localparam int ST_DIF   = 7;
	localparam int ST_ADDR_STOP_FLAG  = 6;
	localparam int ST_DRIVE_CLASH_FLAG  = 3;
	localparam int ST_BERR  = 2;

	// Auxiliary register: bus-state checking enable
	localparam int AUX_CHK = 0;

	// Reset values and bit counts
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] OWN_RST    = 8'h00;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	localparam logic [3:0] FRAME_LAST = 4'h8;

	typedef logic [1:0] irq_lvl_t;

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_HOLD, S_ACK, S_RX, S_TX, S_TX_ACK
	} slv_state_e;

	typedef enum logic [1:0] {AFT_IDLE, AFT_RX, AFT_TXHOLD} after_e;

	// Synchronised line levels and detected conditions
	typedef struct packed {
		logic scl;
		logic sda;
		logic rise;
		logic fall;
		logic start;
		logic stop;
	} line_evt_s;

	// Line synchroniser state
	typedef struct packed {
		logic scl_a;
		logic scl_b;
		logic scl_c;
		logic sda_a;
		logic sda_b;
		logic sda_c;
	} sync_regs_s;

	// Slave control state
	typedef struct packed {
		slv_state_e  st;
		after_e      aft;
		logic [7:0]  ctrl_a;
		logic        ack_choice;
		logic [7:0]  own_addr;
		logic [7:0]  data;
		logic [7:0]  shift;
		logic [3:0]  bitcnt;
		logic [3:0]  frame_cnt;
		logic        frame_open;
		logic        ack_rose;
		logic        byte_done_flag;
		logic        addr_stop_flag;
		logic        hold;
		logic        last_master_ack;
		logic        clash;
		logic        illegal_bus_condition;
		logic        dir;
		logic        ap;
		logic        addressed;
		logic        bus_chk_en;
		logic        sda_drive;
		logic        ph_valid;
		logic        ph_write;
		logic [2:0]  ph_idx;
		logic [31:0] rdata;
	} slv_regs_s;

endpackage

//--- verilog/twi_line_sync.sv
// Two-flop synchroniser and START/STOP/edge finder for SCL and SDA
`timescale 1ns/1ns
module twi_line_sync (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   ce,
	input  wire logic                   scl_i,
	input  wire logic                   sda_i,
	output twi_slave_pkg::line_evt_s    evt
);
	import twi_slave_pkg::*;

	sync_regs_s q;
	sync_regs_s d;

	// Shift both lines through two stages plus a history stage
	always_comb begin
		d = q;
		d.scl_a = scl_i;
		d.scl_b = q.scl_a;
		d.scl_c = q.scl_b;
		d.sda_a = sda_i;
		d.sda_b = q.sda_a;
		d.sda_c = q.sda_b;
	end

	// Lines idle high after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '1;
		end else if (ce) begin
			q <= d;
		end
	end

	// Conditions seen only on the second and third stages
	assign evt.scl   = q.scl_b;
	assign evt.sda   = q.sda_b;
	assign evt.rise  = q.scl_b & ~q.scl_c;
	assign evt.fall  = ~q.scl_b & q.scl_c;
	assign evt.start = q.scl_b & q.scl_c & q.sda_c & ~q.sda_b;
	assign evt.stop  = q.scl_b & q.scl_c & ~q.sda_c & q.sda_b;

endmodule

//--- dv/bus_master_model.sv
// Behavioural two-wire bus master on open-drain SCL and SDA lines
`timescale 1ns/1ns
module bus_master_model (
	input  wire logic scl_line,
	input  wire logic sda_line,
	output logic      scl_pull,
	output logic      sda_pull
);
	// Lines released at time zero; pull-ups make them idle high
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	// Release SCL, then wait out any stretch by the slave
	task automatic rise_scl();
		scl_pull = 1'b0;
		while (scl_line !== 1'b1) #50;
	endtask

	// One bit: SDA moves mid-low, sampled mid-high
	task automatic bit_xfer(input logic b, output logic r);
		#200 sda_pull = !b;
		#200 rise_scl();
		#200 r = sda_line;
		#200 scl_pull = 1'b1;
	endtask

	// START; offset keeps line edges away from hclk edges
	task automatic start();
		#25 sda_pull = 1'b1;
		#400 scl_pull = 1'b1;
	endtask

	// Eight bits MSB first, then the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) bit_xfer(tx[i], rx[i]);
		bit_xfer(ack_in, ack);
	endtask

	// STOP: SDA rises while SCL is high
	task automatic stop();
		#200 sda_pull = 1'b1;
		#200 rise_scl();
		#400 sda_pull = 1'b0;
		#400;
	endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the two-wire slave control block
`timescale 1ns/1ns
`define check_eq(what, exp, got) begin checks_done++; \
	if ((got) !== (exp)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", what, exp, got); end end
module tb_top;
	import twi_slave_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, irq;
	irq_lvl_t    irq_level;
	logic        m_scl, m_sda, ack;
	logic [7:0]  rx;
	logic        acks [4];
	logic [7:0]  wbytes [4] = '{8'ha0, 8'h5a, 8'h3c, 8'h99};
	logic [7:0]  lvl_ctl [3] = '{8'h3c, 8'h6c, 8'h7c};
	int          n_fail = 0;
	int          checks_done = 0;
	wire         scl_line;
	wire         sda_line;

	// Open-drain wires with pull-ups
	assign scl_line = !(scl_oe | m_scl);
	assign sda_line = !(sda_oe | m_sda);

	always #50 hclk = ~hclk;

	twi_slave_ctl i_twi_slave_ctl (.hclk(hclk), .hresetn(hresetn),
		.ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .scl_i(scl_line), .sda_i(sda_line),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
		.irq(irq), .irq_level(irq_level));

	bus_master_model i_bus_master_model (.scl_line(scl_line),
		.sda_line(sda_line), .scl_pull(m_scl), .sda_pull(m_sda));

	// One AHB-Lite single word transfer
	task automatic bus(input logic w, input logic [2:0] idx,
		input logic [7:0] wd, output logic [7:0] rdv);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {27'h0, idx, 2'h0};
		do @(posedge hclk); while (hready_q() !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hready_q() !== 1'b1);
		rdv = hrdata[7:0];
	endtask

	function automatic logic hready_q();
		return hreadyout;
	endfunction

	task automatic wr(input logic [2:0] idx, input logic [7:0] wd);
		logic [7:0] unused;
		bus(1'b1, idx, wd, unused);
	endtask

	task automatic expect_reg(input logic [2:0] idx, input logic [7:0] exp,
		input string what);
		logic [7:0] v;
		bus(1'b0, idx, 8'h00, v);
		`check_eq(what, exp, v)
	endtask

	// Bounded wait for the interrupt request
	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (irq !== 1'b1 && n < 400);
		`check_eq("irq raised", 1'b1, irq)
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main test sequence
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		expect_reg(IDX_STATUS, 8'h00, "status reset");
		expect_reg(3'h5, 8'h00, "unmapped");
		wr(IDX_CTRL_B, 8'h07);
		expect_reg(IDX_CTRL_B, 8'h04, "cmd reads zero");
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_OWN, 8'ha0);
		// Disabled slave, then a foreign address: no acknowledge
		for (int i = 0; i < 2; i++) begin
			wr(IDX_CTRL_A, i ? 8'h7c : 8'h74);
			i_bus_master_model.start();
			i_bus_master_model.xfer(i ? 8'h30 : 8'ha0, 1'b1, rx, ack);
			`check_eq("refused ack", 1'b1, ack)
			i_bus_master_model.stop();
			expect_reg(IDX_STATUS, 8'h00, "idle status");
		end
		// Master write: address, then three data bytes
		fork
			begin
				i_bus_master_model.start();
				for (int b = 0; b < 4; b++) begin
					i_bus_master_model.xfer(wbytes[b], 1'b1, rx, acks[b]);
				end
				i_bus_master_model.stop();
			end
		join_none
		wait_irq();
		expect_reg(IDX_STATUS, 8'h61, "addr flags");
		wr(IDX_CTRL_B, 8'h03);
		@(negedge hclk);
		`check_eq("scl released", 1'b0, scl_oe)
		wait_irq();
		expect_reg(IDX_STATUS, 8'ha1, "byte flags");
		wr(IDX_CTRL_B, 8'h03);
		wait_irq();
		wr(IDX_CTRL_A, 8'h7d);
		expect_reg(IDX_DATA, 8'h3c, "smart read");
		wait_irq();
		wr(IDX_CTRL_B, 8'h06);
		wait fork;
		for (int b = 0; b < 4; b++) begin
			`check_eq("ack seen", b == 3, acks[b])
		end
		expect_reg(IDX_STATUS, 8'h40, "stop flag");
		`check_eq("irq level", 2'h1, irq_level)
		// Level zero and a cleared enable both block the request
		for (int i = 0; i < 3; i++) begin
			wr(IDX_CTRL_A, lvl_ctl[i]);
			@(negedge hclk);
			`check_eq("irq gate", i == 2, irq)
		end
		wr(IDX_STATUS, 8'h40);
		expect_reg(IDX_STATUS, 8'h00, "flag cleared");
		// Match-all accepts a foreign address, completed with ACK
		wr(IDX_CTRL_A, 8'h7e);
		fork
			begin
				i_bus_master_model.start();
				i_bus_master_model.xfer(8'h30, 1'b1, rx, ack);
				i_bus_master_model.stop();
			end
		join_none
		wait_irq();
		expect_reg(IDX_STATUS, 8'h61, "match all");
		wr(IDX_CTRL_B, 8'h02);
		wait fork;
		`check_eq("match-all ack", 1'b0, ack)
		expect_reg(IDX_STATUS, 8'h40, "match-all stop");
		wr(IDX_STATUS, 8'h40);
		// Master read: slave sends one byte, master answers NACK
		fork
			begin
				i_bus_master_model.start();
				i_bus_master_model.xfer(8'ha1, 1'b1, rx, ack);
				i_bus_master_model.xfer(8'hff, 1'b1, rx, ack);
				i_bus_master_model.stop();
			end
		join_none
		wait_irq();
		expect_reg(IDX_STATUS, 8'h63, "read addr");
		wr(IDX_CTRL_B, 8'h03);
		wait_irq();
		expect_reg(IDX_STATUS, 8'ha3, "read byte-done");
		wr(IDX_DATA, 8'hc3);
		wait_irq();
		expect_reg(IDX_STATUS, 8'hb3, "master nack");
		wr(IDX_CTRL_B, 8'h02);
		wait fork;
		`check_eq("sent byte", 8'hc3, rx)
		`check_eq("no slave ack", 1'b1, ack)
		expect_reg(IDX_STATUS, 8'h52, "read stop");
		print_verdict();
	end

	// Watchdog against a hung handshake
	initial begin
		#(30000 * 100);
		n_fail++;
		$display("ERROR watchdog expected finish seen timeout");
		print_verdict();
	end
endmodule
